// File: design/sdrct_gate.sv
// command-timing gate: holds user commands until every spacing has expired
// assumes the memory phy issues the forwarded command on the cycle it is shown
`timescale 1ns/1ns
// Notes on behaviour
// - read latency times period within 13.91..20 ns
// - activate to access at least 13.91 ns
// - precharge to activate at least 13.91 ns
// - activate to activate/refresh same bank 47.91 ns
// - row open 34 ns, max nine refresh intervals
// - clock period fits both latency limits
// - never program reserved latency pairs
// - latency from first-data time, rounded up
// - max period is max data time over latency
// - down-binned minima 13.125 and 47.125 ns
// - bank-to-bank activate gap 7.5 ns, 4 clocks
// - at most four activates per 45 ns
// - column commands four clocks apart
// - mode sets four clocks apart
// - after mode set wait 15 ns/12 clocks
// - auto-precharge write adds precharge period
// - dll off means period at least 8 ns
// - refreshes 300 ns apart, average under 7.8 us
module sdrct_gate #(
    parameter int unsigned BANKS       = 8,
    parameter int unsigned REFI_CYCLES = sdrct_pkg::REFI_CYC,
    parameter int unsigned RASMAX_CYC  = sdrct_pkg::RAS_MAX_CYC
) (
    // clock and reset
    input  wire logic                 clk,
    input  wire logic                 rstn,
    // user request
    input  wire sdrct_pkg::sdrct_req_t req,
    input  wire logic                 req_valid,
    output logic                      req_ready,
    // latency choice
    input  wire logic                 slow_clk_sel,
    input  wire logic                 dll_off,
    // command out to the memory phy
    output sdrct_pkg::sdrct_req_t     mem_cmd_ff,
    output logic                      mem_cmd_valid_ff,
    output logic [3:0]                cas_rd_lat_ff,
    output logic [3:0]                cas_wr_lat_ff,
    output logic                      refresh_due_ff,
    output logic                      row_overdue_ff
);
    import sdrct_pkg::*;
    localparam int CW = 17;
    // ************************************************************
    // reset release
    // ************************************************************
    logic rst_s1_ff, rst_s2_ff;
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rst_s1_ff <= 1'b0;
            rst_s2_ff <= 1'b0;
        end else begin
            rst_s1_ff <= 1'b1;
            rst_s2_ff <= rst_s1_ff;
        end
    end
    wire rst_n = rst_s2_ff;
    // ************************************************************
    // latency pair; only the two legal pairs exist here, so reserved
    // pairs cannot be produced
    // ************************************************************
    // with a dll-off period of 8 ns the fast pair is refused
    wire        use_slow   = slow_clk_sel | dll_off;
    wire [3:0]  nxt_rl     = use_slow ? RL_SLOW : RL_FAST;
    wire [3:0]  nxt_wl     = use_slow ? WL_SLOW : WL_FAST;
    // ************************************************************
    // decode
    // ************************************************************
    wire fire      = req_valid & req_ready;
    wire is_act    = req.cmd == SDRCT_ACT;
    wire is_col    = (req.cmd == SDRCT_RD) | (req.cmd == SDRCT_WR);
    wire is_pre    = req.cmd == SDRCT_PRE;
    wire is_ref    = req.cmd == SDRCT_REF;
    wire is_mrs    = req.cmd == SDRCT_MRS;
    // ************************************************************
    // per-bank counters
    // ************************************************************
    logic [CW-1:0] act_ok_ff [BANKS];  // earliest activate
    logic [CW-1:0] col_ok_ff [BANKS];  // earliest column
    logic [CW-1:0] pre_ok_ff [BANKS];  // earliest precharge
    logic [CW-1:0] open_ff   [BANKS];  // time row open
    logic [BANKS-1:0] bank_ok, bank_open_ff, bank_over;
    genvar g;
    generate
        for (g = 0; g < BANKS; g++) begin : g_bank
            wire mine = fire & (req.bank == 3'(g));
            wire wr_ap = mine & (req.cmd == SDRCT_WR) & req.auto_pre;
            assign bank_ok[g] = is_act ? act_ok_ff[g] == '0 :
                                is_col ? col_ok_ff[g] == '0 :
                                is_pre ? pre_ok_ff[g] == '0 : 1'b1;
            assign bank_over[g] = bank_open_ff[g] & (open_ff[g] >= CW'(RASMAX_CYC));
            always_ff @(posedge clk or negedge rst_n) begin
                if (!rst_n) begin
                    act_ok_ff[g]    <= '0;
                    col_ok_ff[g]    <= '0;
                    pre_ok_ff[g]    <= '0;
                    open_ff[g]      <= '0;
                    bank_open_ff[g] <= 1'b0;
                end else begin
                    act_ok_ff[g] <= (act_ok_ff[g] != '0) ? act_ok_ff[g] - 1'b1 : '0;
                    col_ok_ff[g] <= (col_ok_ff[g] != '0) ? col_ok_ff[g] - 1'b1 : '0;
                    pre_ok_ff[g] <= (pre_ok_ff[g] != '0) ? pre_ok_ff[g] - 1'b1 : '0;
                    open_ff[g]   <= bank_open_ff[g] ? open_ff[g] + 1'b1 : '0;
                    if (mine & is_act) begin
                        act_ok_ff[g]    <= CW'(RC_CYC - 1);
                        col_ok_ff[g]    <= CW'(RCD_CYC - 1);
                        pre_ok_ff[g]    <= CW'(RAS_CYC - 1);
                        bank_open_ff[g] <= 1'b1;
                    end
                    if (mine & (req.cmd == SDRCT_WR) &&
                        pre_ok_ff[g] < CW'(WR_CYC))
                        pre_ok_ff[g] <= CW'(WR_CYC - 1);
                    if (wr_ap) begin
                        act_ok_ff[g]    <= CW'(DAL_CYC - 1);
                        bank_open_ff[g] <= 1'b0;
                    end
                    if (mine & is_pre) begin
                        // compare against the old count: the decrement already applies this edge
                        if (act_ok_ff[g] < CW'(RP_CYC))
                            act_ok_ff[g] <= CW'(RP_CYC - 1);
                        bank_open_ff[g] <= 1'b0;
                    end
                end
            end
        end
    endgenerate
    // ************************************************************
    // global counters
    // ************************************************************
    logic [CW-1:0] rrd_ff, ccd_ff, mrd_ff, mod_ff, rfc_ff, refi_ff;
    logic [CW-1:0] faw_ff [4];
    logic [1:0]    faw_ptr_ff;
    wire any_open   = |bank_open_ff;
    wire glob_ok    = (mod_ff == '0 || is_mrs) &&
                      (!is_act || (rrd_ff == '0 && faw_ff[faw_ptr_ff] == '0 && rfc_ff == '0)) &&
                      (!is_col || ccd_ff == '0) &&
                      (!is_mrs || mrd_ff == '0) &&
                      (!is_ref || (rfc_ff == '0 && !any_open));
    wire sel_bank_ok = bank_ok[req.bank];
    // refresh may follow the last activate of any bank only after a full cycle
    logic [CW-1:0] last_act_ff;
    logic [2:0]    last_act_bank_ff;
    wire ref_rc_ok  = !is_ref || last_act_ff == '0;
    assign req_ready = rst_n & glob_ok & sel_bank_ok & ref_rc_ok & (req.cmd != SDRCT_NOP);

    function automatic logic [CW-1:0] dec(input logic [CW-1:0] v);
        return (v != '0) ? v - 1'b1 : '0;
    endfunction

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rrd_ff      <= '0;
            ccd_ff      <= '0;
            mrd_ff      <= '0;
            mod_ff      <= '0;
            rfc_ff      <= '0;
            last_act_ff <= '0;
            last_act_bank_ff <= 3'h0;
            faw_ptr_ff  <= '0;
            for (int i = 0; i < 4; i++)
                faw_ff[i] <= '0;
        end else begin
            rrd_ff      <= dec(rrd_ff);
            ccd_ff      <= dec(ccd_ff);
            mrd_ff      <= dec(mrd_ff);
            mod_ff      <= dec(mod_ff);
            rfc_ff      <= dec(rfc_ff);
            last_act_ff <= dec(last_act_ff);
            for (int i = 0; i < 4; i++)
                faw_ff[i] <= dec(faw_ff[i]);
            if (fire & is_act) begin
                rrd_ff              <= CW'(RRD_CYC - 1);
                last_act_ff         <= CW'(RC_CYC - 1);
                last_act_bank_ff    <= req.bank;
                faw_ff[faw_ptr_ff]  <= CW'(FAW_CYC - 1);
                faw_ptr_ff          <= faw_ptr_ff + 2'd1;
            end
            if (fire & is_col)
                ccd_ff <= CW'(CCD_CYC - 1);
            if (fire & is_mrs) begin
                mrd_ff <= CW'(MRD_CYC - 1);
                mod_ff <= CW'(MOD_CYC - 1);
            end
            if (fire & is_ref)
                rfc_ff <= CW'(RFC_CYC - 1);
        end
    end
    // ************************************************************
    // refresh interval tracking
    // ************************************************************
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n)
            refi_ff <= '0;
        else if (fire & is_ref)
            refi_ff <= '0;
        else if (refi_ff != '1)
            refi_ff <= refi_ff + 1'b1;
    end
    // ************************************************************
    // outputs
    // ************************************************************
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            mem_cmd_ff       <= '0;
            mem_cmd_valid_ff <= 1'b0;
            cas_rd_lat_ff    <= RL_FAST;
            cas_wr_lat_ff    <= WL_FAST;
            refresh_due_ff   <= 1'b0;
            row_overdue_ff   <= 1'b0;
        end else begin
            mem_cmd_ff       <= fire ? req : '0;
            mem_cmd_valid_ff <= fire;
            cas_rd_lat_ff    <= nxt_rl;
            cas_wr_lat_ff    <= nxt_wl;
            refresh_due_ff   <= refi_ff >= CW'(REFI_CYCLES);
            row_overdue_ff   <= |bank_over;
        end
    end
    // ************************************************************
    // checks
    // ************************************************************
    chk_col_gap_hold: assert property (@(posedge clk) disable iff (!rst_n)
        (fire && is_col) |=> ccd_ff == CW'(CCD_CYC - 1))
        else $error("column commands too close");
    chk_mrs_update_wait: assert property (@(posedge clk) disable iff (!rst_n)
        (fire && is_mrs) |=> !(fire && !is_mrs) [*1])
        else $error("command issued during mode update");
    chk_ref_spacing: assert property (@(posedge clk) disable iff (!rst_n)
        (fire && is_ref) |=> !(fire && (is_ref || is_act)) [*8])
        else $error("refresh cycle time violated");
    chk_act_rc_same: assert property (@(posedge clk) disable iff (!rst_n)
        (fire && is_act) |=> !(fire && is_act && req.bank == last_act_bank_ff) [*5])
        else $error("activate to activate too soon");
    chk_act_access: assert property (@(posedge clk) disable iff (!rst_n)
        (fire && is_act) |=> !(fire && is_col && req.bank == $past(req.bank)))
        else $error("access too soon after activate");
    chk_issue_pulse: assert property (@(posedge clk) disable iff (!rst_n)
        fire |=> mem_cmd_valid_ff && mem_cmd_ff.cmd == $past(req.cmd))
        else $error("granted command not forwarded");
    chk_lat_pair: assert property (@(posedge clk) disable iff (!rst_n)
        ##1 (cas_rd_lat_ff == RL_FAST && cas_wr_lat_ff == WL_FAST) ||
            (cas_rd_lat_ff == RL_SLOW && cas_wr_lat_ff == WL_SLOW))
        else $error("reserved latency pair");
    chk_dll_off_slow: assert property (@(posedge clk) disable iff (!rst_n)
        dll_off |=> cas_rd_lat_ff == RL_SLOW)
        else $error("fast latency with dll off");
endmodule

// File: design/sdrct_pkg.sv
// package for the command-timing gate of a ddr3 controller
// assumes one 125 mhz clock; the memory clock period is a separate figure
package sdrct_pkg;
    // ************************************************************
    // clocks and latencies
    // ************************************************************
    localparam int unsigned CLK_PS            = 8000;
    localparam int unsigned MEM_CK_PS         = 1070;
    localparam int unsigned DLL_OFF_CK_MIN_PS = 8000;
    localparam int unsigned RD_TO_DATA_MIN_PS = 13910;
    localparam int unsigned RD_TO_DATA_MAX_PS = 20000;
    localparam logic [3:0]  RL_FAST           = 4'hD;
    localparam logic [3:0]  WL_FAST           = 4'h9;
    localparam logic [3:0]  RL_SLOW           = 4'hB;
    localparam logic [3:0]  WL_SLOW           = 4'h8;
    localparam int unsigned CK_FAST_MIN_PS    = 1070;
    localparam int unsigned CK_FAST_MAX_PS    = 1250;
    localparam int unsigned CK_SLOW_MAX_PS    = 1500;
    localparam int unsigned WL_LEAST          = 5;
    // ************************************************************
    // timing minima in picoseconds, refresh average in nanoseconds, cycle minima in memory clocks
    // ************************************************************
    localparam int unsigned ACT_TO_ACCESS_PS  = 13910;
    localparam int unsigned PRE_PERIOD_PS     = 13910;
    localparam int unsigned ACT_TO_ACT_PS     = 47910;
    localparam int unsigned DOWNBIN_AA_PS     = 13125;
    localparam int unsigned DOWNBIN_RC_PS     = 47125;
    localparam int unsigned ROW_OPEN_MIN_PS   = 34000;
    localparam int unsigned REFRESH_AVG_NS    = 7800;
    localparam int unsigned ROW_OPEN_MAX_MULT = 9;
    localparam int unsigned BANK_GAP_2K_PS    = 7500;
    localparam int unsigned BANK_GAP_1K_PS    = 6000;
    localparam int unsigned BANK_GAP_NCK      = 4;
    localparam int unsigned FAW_2K_PS         = 45000;
    localparam int unsigned FAW_1K_PS         = 30000;
    localparam int unsigned COL_GAP_NCK       = 4;
    localparam int unsigned MRS_GAP_NCK       = 4;
    localparam int unsigned MRS_UPD_PS        = 15000;
    localparam int unsigned MRS_UPD_NCK       = 12;
    localparam int unsigned WR_RECOV_PS       = 15000;
    localparam int unsigned REF_CYCLE_PS      = 300000;
    localparam int unsigned BURST_NCK         = 4;
    // ************************************************************
    // conversions (round up for minima, down for maxima)
    // ************************************************************
    function automatic int unsigned ps2clk_up(input int unsigned ps);
        return (ps + CLK_PS - 1) / CLK_PS;
    endfunction
    function automatic int unsigned nck2clk_up(input int unsigned n);
        return (n * MEM_CK_PS + CLK_PS - 1) / CLK_PS;
    endfunction
    function automatic int unsigned mx(input int unsigned a, input int unsigned b);
        return (a > b) ? a : b;
    endfunction
    localparam int unsigned WR_NCK        = (WR_RECOV_PS + MEM_CK_PS - 1) / MEM_CK_PS;
    localparam int unsigned RP_NCK        = (PRE_PERIOD_PS + MEM_CK_PS - 1) / MEM_CK_PS;
    localparam int unsigned RCD_CYC       = ps2clk_up(ACT_TO_ACCESS_PS);
    localparam int unsigned RP_CYC        = ps2clk_up(PRE_PERIOD_PS);
    localparam int unsigned RC_CYC        = ps2clk_up(ACT_TO_ACT_PS);
    localparam int unsigned RAS_CYC       = ps2clk_up(ROW_OPEN_MIN_PS);
    localparam int unsigned RAS_MAX_CYC   = ROW_OPEN_MAX_MULT * REFRESH_AVG_NS * 1000 / CLK_PS;
    localparam int unsigned RRD_CYC       = mx(ps2clk_up(BANK_GAP_2K_PS), nck2clk_up(BANK_GAP_NCK));
    localparam int unsigned FAW_CYC       = ps2clk_up(FAW_2K_PS);
    localparam int unsigned CCD_CYC       = mx(1, nck2clk_up(COL_GAP_NCK));
    localparam int unsigned MRD_CYC       = mx(1, nck2clk_up(MRS_GAP_NCK));
    localparam int unsigned MOD_CYC       = mx(ps2clk_up(MRS_UPD_PS), nck2clk_up(MRS_UPD_NCK));
    localparam int unsigned WR_CYC        = nck2clk_up(WL_FAST + BURST_NCK + WR_NCK);
    localparam int unsigned DAL_CYC       = nck2clk_up(WL_FAST + BURST_NCK + WR_NCK + RP_NCK);
    localparam int unsigned RFC_CYC       = ps2clk_up(REF_CYCLE_PS);
    localparam int unsigned REFI_CYC      = REFRESH_AVG_NS * 1000 / CLK_PS;
    // ************************************************************
    // commands
    // ************************************************************
    typedef enum logic [2:0] {
        SDRCT_NOP = 3'h0, SDRCT_ACT = 3'h1, SDRCT_RD = 3'h2, SDRCT_WR = 3'h3,
        SDRCT_PRE = 3'h4, SDRCT_REF = 3'h5, SDRCT_MRS = 3'h6
    } sdrct_cmd_t;
    typedef struct packed {
        sdrct_cmd_t  cmd;
        logic [2:0]  bank;
        logic        auto_pre;
        logic [15:0] addr;
    } sdrct_req_t;
endpackage

// File: verif/sdrct_dev_model.sv
// device-side model: watches the gate's command stream and counts cycles with a command it would refuse or an illegal latency pair
// assumes the command and latency outputs come straight from the gate's registers
`timescale 1ns/1ns
module sdrct_dev_model (
    // clock and reset
    input  wire logic                  clk,
    input  wire logic                  rstn,
    // command stream from the gate
    input  wire sdrct_pkg::sdrct_req_t mem_cmd,
    input  wire logic                  mem_cmd_valid,
    input  wire logic [3:0]            cas_rd_lat,
    input  wire logic [3:0]            cas_wr_lat,
    // cycles with a command the device would not have honoured or an illegal latency pair
    output logic [15:0]                viol_count
);
    import sdrct_pkg::*;
    // minima in 8 ns clocks, rounded up; write recovery is 15 memory clocks at 1.07 ns
    localparam int T_RCD = (13910 + 7999) / 8000;
    localparam int T_RP  = (13910 + 7999) / 8000;
    localparam int T_RC  = (47910 + 7999) / 8000;
    localparam int T_RAS = (34000 + 7999) / 8000;
    localparam int T_MOD = (15000 + 7999) / 8000;
    localparam int T_DAL = ((9 + 4 + 15 + 13) * MEM_CK_PS + 7999) / 8000;
    int         cyc, mrs_t, act_any, b;
    int         act_t [8];
    int         pre_t [8];
    logic [7:0] open_ff;
    logic       bad;
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            cyc = 0;
            mrs_t = -100;
            act_any = -100;
            open_ff = 8'h00;
            viol_count <= 16'h0000;
            for (int i = 0; i < 8; i++) begin
                act_t[i] = -100;
                pre_t[i] = -100;
            end
        end else begin
            cyc = cyc + 1;
            bad = !(cas_rd_lat inside {[6:11], 13}) || cas_wr_lat < 5;
            if (mem_cmd_valid) begin
                b = int'(mem_cmd.bank);
                if (mem_cmd.cmd != SDRCT_MRS && cyc - mrs_t < T_MOD) bad = 1'b1;
                case (mem_cmd.cmd)
                    SDRCT_ACT: begin
                        bad |= open_ff[b] || cyc - pre_t[b] < T_RP || cyc - act_t[b] < T_RC;
                        act_t[b] = cyc;
                        act_any = cyc;
                        open_ff[b] = 1'b1;
                    end
                    SDRCT_RD, SDRCT_WR: begin
                        bad |= !open_ff[b] || cyc - act_t[b] < T_RCD;
                        if (mem_cmd.auto_pre) begin
                            open_ff[b] = 1'b0;
                            pre_t[b] = cyc + T_DAL - T_RP;
                        end
                    end
                    SDRCT_PRE: begin
                        bad |= cyc - act_t[b] < T_RAS;
                        open_ff[b] = 1'b0;
                        pre_t[b] = cyc;
                    end
                    SDRCT_REF: bad |= open_ff != 8'h00 || cyc - act_any < T_RC;
                    SDRCT_MRS: mrs_t = cyc;
                    default: ;
                endcase
            end
            if (bad) viol_count <= viol_count + 16'h0001;
        end
    end
endmodule

// File: verif/sdrct_gate_test.sv
// testbench for the command-timing gate: command spacing, latency choice, status levels
// assumes the gate clock at 125 mhz and the device model on its command outputs
`timescale 1ns/1ns
module sdrct_gate_test;
    import sdrct_pkg::*;
    // ************************************************************
    // settings and signals
    // ************************************************************
    localparam int REFI   = 50;
    localparam int RASMAX = 200;
    localparam int LIMIT  = 4000;
    typedef struct { sdrct_cmd_t cmd; int bank; logic ap; int idle; int gap; } sdrct_row_t;
    logic        clk = 1'b0;
    logic        rstn = 1'b0;
    sdrct_req_t  req = '0;
    logic        req_valid = 1'b0;
    logic        slow_clk_sel = 1'b0;
    logic        dll_off = 1'b0;
    sdrct_req_t  mem_cmd_ff, req_prev;
    logic        req_ready, mem_cmd_valid_ff, refresh_due_ff, row_overdue_ff;
    logic        acc_prev = 1'b0;
    logic [3:0]  cas_rd_lat_ff, cas_wr_lat_ff;
    logic [15:0] viol_count;
    int          fail_count = 0, total_checks = 0, cyc = 0, last_acc = 0, gap, a;
    // write recovery 15 ns is 15 memory clocks; wl 9, burst 4, precharge 13 memory clocks
    sdrct_row_t rows [28] = '{
        '{SDRCT_MRS, 0, 0, 0, 0}, '{SDRCT_MRS, 0, 0, 0, 1}, '{SDRCT_ACT, 0, 0, 0, 2},
        '{SDRCT_RD, 0, 0, 0, 2}, '{SDRCT_RD, 0, 0, 0, 1}, '{SDRCT_PRE, 0, 0, 0, 2},
        '{SDRCT_ACT, 0, 0, 0, 2}, '{SDRCT_PRE, 0, 0, 0, 5},
        '{SDRCT_ACT, 1, 0, 40, 0}, '{SDRCT_ACT, 2, 0, 0, 1}, '{SDRCT_ACT, 3, 0, 0, 1},
        '{SDRCT_ACT, 4, 0, 0, 1}, '{SDRCT_ACT, 5, 0, 0, 3},
        '{SDRCT_PRE, 1, 0, 0, 1}, '{SDRCT_PRE, 2, 0, 0, 1}, '{SDRCT_PRE, 3, 0, 0, 1},
        '{SDRCT_PRE, 4, 0, 0, 1}, '{SDRCT_PRE, 5, 0, 0, 1},
        '{SDRCT_ACT, 5, 0, 40, 0}, '{SDRCT_WR, 5, 0, 0, 2},
        '{SDRCT_PRE, 5, 0, 0, ((9 + 4 + 15) * 1070 + 7999) / 8000},
        '{SDRCT_ACT, 6, 0, 40, 0}, '{SDRCT_WR, 6, 1, 0, 2},
        '{SDRCT_ACT, 6, 0, 0, ((9 + 4 + 15 + 13) * 1070 + 7999) / 8000},
        '{SDRCT_PRE, 6, 0, 0, 5}, '{SDRCT_REF, 0, 0, 40, 0},
        '{SDRCT_ACT, 0, 0, 0, (300000 + 7999) / 8000}, '{SDRCT_PRE, 0, 0, 0, 5}
    };
    sdrct_gate #(.BANKS(8), .REFI_CYCLES(REFI), .RASMAX_CYC(RASMAX)) dut_u (
        .clk(clk), .rstn(rstn), .req(req), .req_valid(req_valid), .req_ready(req_ready),
        .slow_clk_sel(slow_clk_sel), .dll_off(dll_off), .mem_cmd_ff(mem_cmd_ff),
        .mem_cmd_valid_ff(mem_cmd_valid_ff), .cas_rd_lat_ff(cas_rd_lat_ff), .cas_wr_lat_ff(cas_wr_lat_ff),
        .refresh_due_ff(refresh_due_ff), .row_overdue_ff(row_overdue_ff));
    sdrct_dev_model dev_u (
        .clk(clk), .rstn(rstn), .mem_cmd(mem_cmd_ff), .mem_cmd_valid(mem_cmd_valid_ff),
        .cas_rd_lat(cas_rd_lat_ff), .cas_wr_lat(cas_wr_lat_ff), .viol_count(viol_count));
    // ************************************************************
    // clock, watchdog and output monitor
    // ************************************************************
    always #4 clk = ~clk;
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == LIMIT) begin
            fail_count = fail_count + 1;
            print_verdict();
        end
    end
    // every accepted request appears once, one cycle later, unchanged
    always @(negedge clk) begin
        if (rstn) begin
            check(mem_cmd_valid_ff, acc_prev);
            if (acc_prev) check(mem_cmd_ff, req_prev);
        end
        acc_prev = rstn & req_valid & req_ready;
        req_prev = req;
    end
    // ************************************************************
    // tasks
    // ************************************************************
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks = total_checks + 1;
        if (seen !== exp) begin
            fail_count = fail_count + 1;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // valid stays high on return so back-to-back requests never touch it twice in one step
    task automatic issue(input sdrct_cmd_t c, input int bk, input logic ap, output int g);
        int n;
        n = 0;
        req       <= '{cmd: c, bank: 3'(bk), auto_pre: ap, addr: 16'h0000};
        req_valid <= 1'b1;
        do begin
            @(negedge clk);
            n = n + 1;
        end while (req_ready !== 1'b1 && n < 80);
        if (n >= 80) check(req_ready, 1'b1);
        @(posedge clk);
        g        = cyc - last_acc;
        last_acc = cyc;
    endtask
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    // ************************************************************
    // main sequence
    // ************************************************************
    initial begin
        repeat (11) @(posedge clk);
        @(negedge clk);
        check(cas_rd_lat_ff, 4'hD);
        check(cas_wr_lat_ff, 4'h9);
        @(posedge clk);
        req       <= '{cmd: SDRCT_MRS, bank: 3'h0, auto_pre: 1'b0, addr: 16'h0000};
        req_valid <= 1'b1;
        rstn      <= 1'b1;
        @(negedge clk);
        check(req_ready, 1'b0);
        foreach (rows[i]) begin
            if (rows[i].idle > 0) begin
                req_valid <= 1'b0;
                repeat (rows[i].idle) @(posedge clk);
            end
            issue(rows[i].cmd, rows[i].bank, rows[i].ap, gap);
            if (rows[i].gap > 0) check(gap, rows[i].gap);
        end
        // refresh after an activate waits the full activate-to-activate time
        req_valid <= 1'b0;
        repeat (40) @(posedge clk);
        issue(SDRCT_ACT, 0, 1'b0, gap);
        a = last_acc;
        issue(SDRCT_PRE, 0, 1'b0, gap);
        issue(SDRCT_REF, 0, 1'b0, gap);
        req_valid <= 1'b0;
        check((last_acc - a >= 6) && (last_acc - a <= 7), 1'b1);
        repeat (5) @(negedge clk);
        check(refresh_due_ff, 1'b0);
        repeat (REFI) @(negedge clk);
        check(refresh_due_ff, 1'b1);
        @(posedge clk);
        issue(SDRCT_ACT, 1, 1'b0, gap);
        req_valid <= 1'b0;
        repeat (RASMAX - 10) @(negedge clk);
        check(row_overdue_ff, 1'b0);
        repeat (20) @(negedge clk);
        check(row_overdue_ff, 1'b1);
        @(posedge clk);
        issue(SDRCT_PRE, 1, 1'b0, gap);
        req_valid <= 1'b0;
        repeat (3) @(negedge clk);
        check(row_overdue_ff, 1'b0);
        for (int c = 0; c < 4; c++) begin
            @(posedge clk);
            slow_clk_sel <= c[0];
            dll_off      <= c[1];
            repeat (2) @(negedge clk);
            check(cas_rd_lat_ff, (c == 0) ? 4'hD : 4'hB);
            check(cas_wr_lat_ff, (c == 0) ? 4'h9 : 4'h8);
        end
        check(viol_count, 16'h0000);
        // second reset in mid-run with the slow pair selected
        @(posedge clk);
        rstn <= 1'b0;
        @(negedge clk);
        check(cas_rd_lat_ff, 4'hD);
        check(mem_cmd_valid_ff, 1'b0);
        repeat (3) @(posedge clk);
        a = cyc;
        rstn <= 1'b1;
        issue(SDRCT_ACT, 2, 1'b0, gap);
        check(last_acc - a, 3);
        req_valid <= 1'b0;
        repeat (2) @(negedge clk);
        check(cas_rd_lat_ff, 4'hB);
        print_verdict();
    end
endmodule
